// *** logic/i2c_port_cfg.svh ***
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// register index of the port config word, byte address is four times it
`define CFG_IDX 8'h3F
`define CFG_ADDR 12'h0FC
`define PEND2_ADDR 12'h100
`define MASK2_ADDR 12'h104
`define ROLE_ADDR 12'h108
`define STATE_ADDR 12'h10C

// port config fields and reset value
`define CFG_RATE_BIT 0
`define CFG_EARLY_WRITE_ACK_BIT 1
`define CFG_FRAME_BIT 2
`define CFG_RESET 3'h0

// pending and mask fields
`define PEND_ERR_BIT 0
`define PEND_DONE_BIT 1
`define PEND_RESET 2'h0
`define ROLE_RESET 1'h0

// timing: reference clock, frame rates and local bus speeds in Hz
`define REF_CLK_HZ 64'd40000000
`define FRAME_48_HZ 64'd48000
`define FRAME_441_HZ 64'd44100
`define SPEED_STD_HZ 64'd100000
`define SPEED_FAST_HZ 64'd400000
// half period in cycles, system clock scales with the frame rate; rounds up
`define HALF_CYC(FR, SP) \
  ((`REF_CLK_HZ * (FR) + 64'd2 * `FRAME_48_HZ * (SP) - 64'd1) / (64'd2 * `FRAME_48_HZ * (SP)))

`endif

// *** logic/i2c_port_pkg.sv ***
package i2c_port_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_HOLD = 6'h08,
    ST_WAIT = 6'h10,
    ST_SKIP = 6'h20
  } port_state_t;

  typedef struct packed {
    port_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic is_addr;
    logic ack_seen_rise;
    logic sda_drv;
    logic scl_drv;
    logic [6:0] tgt_addr;
    logic rem_busy;
    logic rem_early;
    logic [6:0] rem_addr;
    logic [7:0] rem_data;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] cfg;
    logic role_ctrl;
    logic [1:0] pend;
    logic [1:0] mask;
    logic rdy;
    logic slverr;
    logic [31:0] prdata;
    logic [8:0] gen_cnt;
    logic local_scl;
  } port_regs_t;

endpackage

// *** logic/i2c_port_ack_rate.sv ***
`timescale 1ns/1ps
`include "i2c_port_cfg.svh"

module i2c_port_ack_rate #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_line,
  output logic scl_pull,
  output logic scl_oe_n,
  input wire logic sda_line,
  output logic sda_pull,
  output logic sda_oe_n,
  output logic rem_req,
  output logic [6:0] rem_addr,
  output logic [7:0] rem_data,
  input wire logic rem_done,
  input wire logic rem_err,
  output logic local_scl,
  output logic irq
);

  localparam logic [8:0] HALF_STD_48 = 9'(`HALF_CYC(`FRAME_48_HZ, `SPEED_STD_HZ));
  localparam logic [8:0] HALF_FAST_48 = 9'(`HALF_CYC(`FRAME_48_HZ, `SPEED_FAST_HZ));
  localparam logic [8:0] HALF_STD_441 = 9'(`HALF_CYC(`FRAME_441_HZ, `SPEED_STD_HZ));
  localparam logic [8:0] HALF_FAST_441 = 9'(`HALF_CYC(`FRAME_441_HZ, `SPEED_FAST_HZ));

  if (ADDR_W < 9)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  i2c_port_pkg::port_regs_t r;
  i2c_port_pkg::port_regs_t nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic acc;
  logic early_write_ack_eff;
  logic [8:0] half_cyc;
  logic [31:0] rd_val;
  logic rd_hit;

  // edge and bus condition detection uses the second and third sync stages only
  assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
  assign start_cond = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
  assign stop_cond = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
  // the write or read takes effect on the edge where pready is seen high
  assign acc = psel & penable & r.rdy;

  assign early_write_ack_eff = r.role_ctrl & r.cfg[`CFG_EARLY_WRITE_ACK_BIT];

  always_comb
  begin
    case ({r.cfg[`CFG_FRAME_BIT], r.cfg[`CFG_RATE_BIT]})
      2'b00: half_cyc = HALF_STD_48;
      2'b01: half_cyc = HALF_FAST_48;
      2'b10: half_cyc = HALF_STD_441;
      default: half_cyc = HALF_FAST_441;
    endcase
  end

  // read mux, unmapped addresses answer with an error
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `CFG_ADDR: rd_val = {29'h0000_0000, r.cfg};
      `PEND2_ADDR: rd_val = {30'h0000_0000, r.pend};
      `MASK2_ADDR: rd_val = {30'h0000_0000, r.mask};
      `ROLE_ADDR: rd_val = {31'h0000_0000, r.role_ctrl};
      `STATE_ADDR: rd_val = {30'h0000_0000, r.scl_drv, r.rem_busy};
      default: rd_hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    nxt = r;
    nxt.scl_s = {r.scl_s[1:0], scl_line};
    nxt.sda_s = {r.sda_s[1:0], sda_line};

    // apb slave: one wait state, then answer from flip-flops
    nxt.rdy = psel & penable & ~r.rdy;
    if (psel & penable & ~r.rdy)
    begin
      nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
      nxt.slverr = ~rd_hit;
    end
    if (acc & pwrite & rd_hit)
    begin
      case (paddr)
        `CFG_ADDR: nxt.cfg = pwdata[2:0];
        `MASK2_ADDR: nxt.mask = pwdata[1:0];
        `ROLE_ADDR: nxt.role_ctrl = pwdata[0];
        default: nxt.cfg = r.cfg;
      endcase
    end
    // read clears pending bits; events below set them again and so win
    if (acc & ~pwrite & (paddr == `PEND2_ADDR))
    begin
      nxt.pend = 2'h0;
    end

    // remote completion
    if (r.rem_busy & rem_done)
    begin
      nxt.rem_busy = 1'b0;
      if (r.rem_early & rem_err)
      begin
        nxt.pend[`PEND_ERR_BIT] = 1'b1;
      end
      if (~rem_err)
      begin
        nxt.pend[`PEND_DONE_BIT] = 1'b1;
      end
    end

    // host-facing i2c target
    case (r.st)
      i2c_port_pkg::ST_IDLE:
      begin
        nxt.sda_drv = 1'b0;
      end
      i2c_port_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          nxt.shift = {r.shift[6:0], r.sda_s[1]};
          nxt.bitcnt = r.bitcnt + 4'h1;
        end
        else if (scl_fall & (r.bitcnt == 4'h8))
        begin
          nxt.bitcnt = 4'h0;
          if (r.is_addr)
          begin
            // only writes are served; reads are left unanswered
            nxt.is_addr = 1'b0;
            nxt.tgt_addr = r.shift[7:1];
            nxt.st = r.shift[0] ? i2c_port_pkg::ST_SKIP : i2c_port_pkg::ST_ACK;
            nxt.sda_drv = ~r.shift[0];
          end
          else
          begin
            // hold the clock low until the remote write is launched, and without early ack until it ends
            nxt.scl_drv = 1'b1;
            nxt.st = i2c_port_pkg::ST_HOLD;
          end
        end
      end
      i2c_port_pkg::ST_HOLD:
      begin
        if (~nxt.rem_busy)
        begin
          nxt.rem_busy = 1'b1;
          nxt.rem_early = early_write_ack_eff;
          nxt.rem_addr = r.tgt_addr;
          nxt.rem_data = r.shift;
          if (early_write_ack_eff)
          begin
            nxt.scl_drv = 1'b0;
            nxt.sda_drv = 1'b1;
            nxt.st = i2c_port_pkg::ST_ACK;
          end
          else
          begin
            nxt.st = i2c_port_pkg::ST_WAIT;
          end
        end
      end
      i2c_port_pkg::ST_WAIT:
      begin
        if (rem_done)
        begin
          nxt.scl_drv = 1'b0;
          nxt.sda_drv = ~rem_err;
          nxt.st = i2c_port_pkg::ST_ACK;
        end
      end
      i2c_port_pkg::ST_ACK:
      begin
        if (scl_rise)
        begin
          nxt.ack_seen_rise = 1'b1;
        end
        else if (scl_fall & r.ack_seen_rise)
        begin
          nxt.ack_seen_rise = 1'b0;
          nxt.sda_drv = 1'b0;
          nxt.st = i2c_port_pkg::ST_RX;
        end
      end
      i2c_port_pkg::ST_SKIP:
      begin
        nxt.sda_drv = 1'b0;
      end
      default:
      begin
        nxt.st = i2c_port_pkg::ST_IDLE;
      end
    endcase

    // start and stop override the byte engine, except while the clock is held
    if (~r.scl_drv & start_cond)
    begin
      nxt.st = i2c_port_pkg::ST_RX;
      nxt.is_addr = 1'b1;
      nxt.bitcnt = 4'h0;
      nxt.sda_drv = 1'b0;
      nxt.ack_seen_rise = 1'b0;
    end
    else if (~r.scl_drv & stop_cond)
    begin
      nxt.st = i2c_port_pkg::ST_IDLE;
      nxt.sda_drv = 1'b0;
      nxt.ack_seen_rise = 1'b0;
    end

    // local clock generator, only in a target node
    if (r.role_ctrl)
    begin
      nxt.gen_cnt = 9'h000;
      nxt.local_scl = 1'b1;
    end
    else if (r.gen_cnt >= half_cyc - 9'h001)
    begin
      nxt.gen_cnt = 9'h000;
      nxt.local_scl = ~r.local_scl;
    end
    else
    begin
      nxt.gen_cnt = r.gen_cnt + 9'h001;
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '{st: i2c_port_pkg::ST_IDLE, bitcnt: 4'h0, shift: 8'h00, is_addr: 1'b0,
             ack_seen_rise: 1'b0, sda_drv: 1'b0, scl_drv: 1'b0, tgt_addr: 7'h00,
             rem_busy: 1'b0, rem_early: 1'b0, rem_addr: 7'h00, rem_data: 8'h00,
             scl_s: 3'h7, sda_s: 3'h7, cfg: `CFG_RESET, role_ctrl: `ROLE_RESET,
             pend: `PEND_RESET, mask: 2'h0, rdy: 1'b0, slverr: 1'b0,
             prdata: 32'h0000_0000, gen_cnt: 9'h000, local_scl: 1'b1};
    end
    else
    begin
      r <= nxt;
    end
  end

  // outputs; open-drain pins only ever pull low
  assign prdata = r.prdata;
  assign pready = r.rdy;
  assign pslverr = r.slverr;
  assign scl_pull = 1'b0;
  assign sda_pull = 1'b0;
  assign scl_oe_n = ~r.scl_drv;
  assign sda_oe_n = ~r.sda_drv;
  assign rem_req = r.rem_busy;
  assign rem_addr = r.rem_addr;
  assign rem_data = r.rem_data;
  assign local_scl = r.local_scl;
  assign irq = |(r.pend & r.mask);

endmodule

// *** verif/i2c_port_ack_rate_sva.sv ***
`timescale 1ns/1ps
`include "i2c_port_cfg.svh"
module i2c_port_ack_rate_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic rem_req,
  input wire logic rem_done,
  input wire logic rem_err,
  input wire logic local_scl,
  input wire logic irq
);
  logic [2:0] cfg_r;
  logic role_r, mask_r, ls_r, wr, early;
  logic [8:0] age_r, run_r;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign early = role_r && cfg_r[`CFG_EARLY_WRITE_ACK_BIT];
  // shadow config; age waits out a rate change before the period is judged
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_r <= 3'h0;
      role_r <= 1'h0;
      mask_r <= 1'h0;
      ls_r <= 1'h1;
      age_r <= 9'h0;
      run_r <= 9'h0;
    end
    else
    begin
      ls_r <= local_scl;
      run_r <= (local_scl != ls_r) ? 9'h1 : run_r + 9'h1;
      age_r <= wr ? 9'h0 : age_r + {8'h0, age_r != 9'h1FF};
      if (wr && paddr == `CFG_ADDR) cfg_r <= pwdata[2:0];
      if (wr && paddr == `ROLE_ADDR) role_r <= pwdata[0];
      if (wr && paddr == `MASK2_ADDR) mask_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_early; $rose(rem_req) && early |-> ##[0:1] (scl_oe_n && !sda_oe_n); endproperty
  a_early: assert property (p_early) else $error("no early ack");
  property p_errflag; rem_req && rem_done && rem_err && early && mask_r |=> ##[0:2] irq; endproperty
  a_errflag: assert property (p_errflag) else $error("no error irq");
  property p_hold; rem_req && !early |-> !scl_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_true; rem_req && rem_done && !early |=> scl_oe_n && sda_oe_n == $past(rem_err); endproperty
  a_true: assert property (p_true) else $error("wrong ack");
  property p_rate; age_r == 9'h1FF && local_scl != ls_r && !role_r |-> run_r ==
    (cfg_r[2] ? (cfg_r[0] ? 9'h2E : 9'hB8) : (cfg_r[0] ? 9'h32 : 9'hC8)); endproperty
  a_rate: assert property (p_rate) else $error("bad local half period");
  property p_role; role_r && $past(role_r, 2) |-> local_scl; endproperty
  a_role: assert property (p_role) else $error("local clock runs");
endmodule
bind i2c_port_ack_rate i2c_port_ack_rate_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .scl_oe_n, .sda_oe_n, .rem_req,
  .rem_done, .rem_err, .local_scl, .irq);

// *** verif/host_i2c_model.sv ***
`timescale 1ns/1ps
module host_i2c_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_h,
  output logic sda_h
);
  logic tick = 1'h0;
  // own quarter-bit tick, phase unrelated to the block clock
  initial
  begin
    scl_h = 1'h1;
    sda_h = 1'h1;
    #7;
    forever #25 tick = ~tick;
  end
  // high phase waits out any stretch, bounded
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    @(posedge tick) scl_h = 1'h1;
    for (int i = 0; i < 9000 && scl !== 1'h1; i++) @(posedge tick);
    // a clock still held after the bound reads back as a bad bit
    @(posedge tick) r = (scl === 1'h1) ? sda : 1'hx;
    @(posedge tick) scl_h = 1'h0;
    @(posedge tick);
  endtask
  // one byte msb first, then the ack bit
  task automatic byte_io(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(d[k], r);
    bit_io(1'h1, ack);
  endtask
  // start, address with write, one data byte, stop
  task automatic wr_xfer(input logic [6:0] a, input logic [7:0] d, output logic [1:0] acks);
    @(posedge tick) sda_h = 1'h0;
    @(posedge tick) scl_h = 1'h0;
    byte_io({a, 1'h0}, acks[1]);
    byte_io(d, acks[0]);
    sda_h = 1'h0;
    @(posedge tick) scl_h = 1'h1;
    @(posedge tick) sda_h = 1'h1;
  endtask
endmodule

// *** verif/i2c_port_ack_rate_bench.sv ***
`timescale 1ns/1ps
`include "i2c_port_cfg.svh"
module i2c_port_ack_rate_bench;
  logic ref_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rem_done = 1'h0, rem_err = 1'h0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl_pull, scl_oe_n, sda_pull, sda_oe_n;
  logic rem_req, local_scl, irq, scl_h, sda_h;
  logic [6:0] rem_addr;
  logic [7:0] rem_data;
  logic [1:0] acks;
  int n_errors = 0, samples_checked = 0, dly = 0, cnt = 0;
  wire scl = scl_h & (scl_oe_n | scl_pull);
  wire sda = sda_h & (sda_oe_n | sda_pull);
  i2c_port_ack_rate dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_line(scl), .scl_pull, .scl_oe_n,
    .sda_line(sda), .sda_pull, .sda_oe_n,
    .rem_req, .rem_addr, .rem_data, .rem_done, .rem_err, .local_scl, .irq);
  host_i2c_model host (.scl, .sda, .scl_h, .sda_h);
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // remote side finishes dly + 1 cycles after launch
  always @(posedge ref_clk)
  begin
    rem_done <= rem_req && !rem_done && cnt == dly;
    cnt <= (rem_req && !rem_done) ? cnt + 1 : 0;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // reset values, read-back and an unmapped place
  task automatic t_regs();
    rdchk(`CFG_ADDR, 32'h0);
    rdchk(`ROLE_ADDR, 32'h0);
    rdchk(`PEND2_ADDR, 32'h0);
    apb(1'h1, `CFG_ADDR, 32'hFFFFFFFF);
    rdchk(`CFG_ADDR, 32'h7);
    rdchk(12'h200, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  // all speed and frame settings, judged by the checker
  task automatic t_rate();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, `CFG_ADDR, {29'h0, i[1], 1'h0, i[0]});
      repeat (1000) @(posedge ref_clk);
    end
    $display("t_rate done");
  endtask
  // target role stretches even with early ack set
  task automatic t_stretch();
    apb(1'h1, `CFG_ADDR, 32'h2);
    dly = 40;
    for (int e = 0; e < 2; e++)
    begin
      @(posedge ref_clk);
      rem_err <= e[0];
      host.wr_xfer(7'h2A, 8'hC3, acks);
      chk({30'h0, acks}, {31'h0, e[0]});
    end
    // only the clean remote write leaves its done flag
    rdchk(`PEND2_ADDR, 32'h2);
    $display("t_stretch done");
  endtask
  // early ack ahead of a failing remote write
  task automatic t_early();
    apb(1'h1, `ROLE_ADDR, 32'h1);
    apb(1'h1, `MASK2_ADDR, 32'h1);
    apb(1'h0, `PEND2_ADDR, 32'h0);
    dly = 400;
    rem_err <= 1'h1;
    host.wr_xfer(7'h15, 8'h5A, acks);
    chk({30'h0, acks}, 32'h0);
    chk({31'h0, rem_req}, 32'h1);
    chk({25'h0, rem_addr}, 32'h15);
    chk({24'h0, rem_data}, 32'h5A);
    rdchk(`STATE_ADDR, 32'h1);
    // a second write is held on the clock until the first remote write ends
    host.wr_xfer(7'h16, 8'hA5, acks);
    chk({30'h0, acks}, 32'h0);
    chk({25'h0, rem_addr}, 32'h16);
    repeat (450) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `MASK2_ADDR, 32'h0);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rdchk(`PEND2_ADDR, 32'h1);
    rdchk(`PEND2_ADDR, 32'h0);
    $display("t_early done");
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'h1;
    t_regs();
    t_rate();
    t_stretch();
    t_early();
    close_out();
  end
  // watchdog, well past the expected run
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
endmodule
